//--- config_index_data_bank.sv
`timescale 1ns/100ps
module config_index_data_bank #(
	parameter bit VARIANT_B = 1'b0
) (
	// Clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic sys_reset,
	// Host I/O cycle
	input wire logic [9:0] io_addr,
	input wire logic io_wr_stb,
	input wire logic io_rd_stb,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out_ff,
	output logic data_oe_ff,
	// Status inputs
	input wire logic power_good_input,
	input wire logic par_ext_active,
	input wire logic [bank_pkg::IRQ_LINES-1:0] irq_raw,
	// Mode
	output logic config_mode_ff,
	// Drive, floppy, clock and valid controls
	output logic hdd_if_enable_ff,
	output logic drive_interface_type_ff,
	output logic floppy_power_on_ff,
	output logic floppy_unit_enable_ff,
	output logic osc_enable_ff,
	output logic baud_clock_enable_ff,
	output logic config_valid_ff,
	// Parallel port controls
	output logic par_enable_ff,
	output logic [9:0] par_base_ff,
	output logic par_power_on_ff,
	output logic par_printer_mode_ff,
	// Extra serial port addresses
	output logic [9:0] com3_base_ff,
	output logic [9:0] com4_base_ff,
	// Interrupt pins
	output logic [bank_pkg::IRQ_LINES-1:0] irq_out_ff,
	output logic [bank_pkg::IRQ_LINES-1:0] irq_oe_ff
);
	localparam logic [7:0] CR0_DEF = VARIANT_B ? bank_pkg::CR0_DEF_B : bank_pkg::CR0_DEF_A;

	logic [7:0] drive_osc_config_ff;
	logic [7:0] port_address_config_ff;
	logic [7:0] mem_ff [bank_pkg::MEM_FIRST:bank_pkg::MEM_LAST];
	logic [7:0] config_index_select_ff;
	logic index_loaded_ff;
	logic mode_now;

	logic sel_hit;
	logic data_hit;
	logic wr_sel;
	logic access_ok;
	logic wr_data;
	logic rd_data;
	logic lock_open;
	logic [7:0] rd_mux;
	logic [7:0] cr0_wr_val;
	logic [7:0] cr1_wr_val;
	logic [1:0] osc_mode;
	logic [1:0] par_sel;
	logic [1:0] com_sel;

	logic nxt_osc_enable;
	logic [9:0] nxt_par_base;
	logic [9:0] nxt_com3_base;
	logic [9:0] nxt_com4_base;

	// Index names register n; equality only, load and range are checked elsewhere
	function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] n);
		idx_is = idx == n;
	endfunction

	// Unlock sequence and mode tracking
	unlock_seq u_unlock (
		.clk(clk),
		.rst(rst),
		.sys_reset(sys_reset),
		.wr_stb(io_wr_stb),
		.addr(io_addr),
		.wdata(data_in),
		.config_mode_ff(mode_now)
	);

	// Interrupt pin polarity
	irq_drive u_irq (
		.clk(clk),
		.rst(rst),
		.active_high(port_address_config_ff[bank_pkg::CR1_IRQ_POL]),
		.par_ext_mode(par_ext_active),
		.irq_raw(irq_raw),
		.irq_out_ff(irq_out_ff),
		.irq_oe_ff(irq_oe_ff)
	);

	assign config_mode_ff = mode_now;

	// Port decode; both ports are dead outside config mode
	assign sel_hit = io_addr == bank_pkg::SELECT_PORT;
	assign data_hit = io_addr == bank_pkg::DATA_PORT;
	assign wr_sel = io_wr_stb && sel_hit && mode_now && data_in != bank_pkg::EXIT_KEY;
	assign lock_open = port_address_config_ff[bank_pkg::CR1_LOCK];
	assign access_ok = mode_now && index_loaded_ff && lock_open
		&& config_index_select_ff < bank_pkg::IDX_LIMIT;
	assign wr_data = io_wr_stb && data_hit && access_ok;
	assign rd_data = io_rd_stb && data_hit && access_ok;

	// Write values; reserved bit kept clear, lock can only fall
	assign cr0_wr_val = data_in & ~(8'h01 << bank_pkg::CR0_RSVD);
	assign cr1_wr_val = {data_in[bank_pkg::CR1_LOCK] & lock_open, data_in[bank_pkg::CR1_LOCK-1:0]};

	// Read selection
	assign rd_mux = idx_is(config_index_select_ff, bank_pkg::IDX_CR0) ? drive_osc_config_ff
		: idx_is(config_index_select_ff, bank_pkg::IDX_CR1) ? port_address_config_ff
		: mem_ff[config_index_select_ff[3:0]];

	// Index register; loaded flag dropped outside config mode so stale indexes cannot leak
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_index_select_ff <= 8'h00;
			index_loaded_ff <= 1'b0;
		end else if (!mode_now) begin
			index_loaded_ff <= 1'b0;
		end else if (wr_sel) begin
			config_index_select_ff <= data_in;
			index_loaded_ff <= 1'b1;
		end
	end

	// Registers 0 and 1; sys_reset deliberately not in this process
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_osc_config_ff <= CR0_DEF;
			port_address_config_ff <= bank_pkg::CR1_DEF;
		end else if (wr_data) begin
			if (idx_is(config_index_select_ff, bank_pkg::IDX_CR0)) begin
				drive_osc_config_ff <= cr0_wr_val;
			end
			if (idx_is(config_index_select_ff, bank_pkg::IDX_CR1)) begin
				port_address_config_ff <= cr1_wr_val;
			end
		end
	end

	// Remaining registers held as plain storage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int k = bank_pkg::MEM_FIRST; k <= bank_pkg::MEM_LAST; k++) begin
				mem_ff[k] <= bank_pkg::MEM_DEF;
			end
		end else if (wr_data && config_index_select_ff >= 8'(bank_pkg::MEM_FIRST)) begin
			mem_ff[config_index_select_ff[3:0]] <= data_in;
		end
	end

	// Read answer one cycle after the strobe, for one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out_ff <= 8'h00;
			data_oe_ff <= 1'b0;
		end else begin
			data_out_ff <= rd_data ? rd_mux : 8'h00;
			data_oe_ff <= rd_data;
		end
	end

	// Field decode
	assign osc_mode = drive_osc_config_ff[bank_pkg::CR0_OSC_HI:bank_pkg::CR0_OSC_LO];
	assign par_sel = port_address_config_ff[bank_pkg::CR1_PAR_HI:bank_pkg::CR1_PAR_LO];
	assign com_sel = port_address_config_ff[bank_pkg::CR1_COM_HI:bank_pkg::CR1_COM_LO];
	// Modes 01 and 10 follow power good; the clock gate itself lives elsewhere
	assign nxt_osc_enable = osc_mode == bank_pkg::OSC_ALWAYS
		|| (osc_mode != bank_pkg::OSC_OFF && power_good_input);
	assign nxt_par_base = par_sel == 2'h1 ? bank_pkg::PAR_ADDR_1
		: par_sel == 2'h2 ? bank_pkg::PAR_ADDR_2
		: par_sel == 2'h3 ? bank_pkg::PAR_ADDR_3 : bank_pkg::ADDR_NONE;
	assign nxt_com3_base = com_sel == 2'h1 ? bank_pkg::COM3_ADDR_1
		: com_sel == 2'h2 ? bank_pkg::COM3_ADDR_2
		: com_sel == 2'h3 ? bank_pkg::COM3_ADDR_3 : bank_pkg::COM3_ADDR_0;
	assign nxt_com4_base = com_sel == 2'h1 ? bank_pkg::COM4_ADDR_1
		: com_sel == 2'h2 ? bank_pkg::COM4_ADDR_2
		: com_sel == 2'h3 ? bank_pkg::COM4_ADDR_3 : bank_pkg::COM4_ADDR_0;

	// Control outputs trail the register by one cycle to stay glitch free
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hdd_if_enable_ff <= 1'b0;
			drive_interface_type_ff <= 1'b0;
			floppy_power_on_ff <= 1'b0;
			floppy_unit_enable_ff <= 1'b0;
			osc_enable_ff <= 1'b0;
			baud_clock_enable_ff <= 1'b0;
			config_valid_ff <= 1'b0;
			par_enable_ff <= 1'b0;
			par_base_ff <= bank_pkg::ADDR_NONE;
			par_power_on_ff <= 1'b0;
			par_printer_mode_ff <= 1'b0;
			com3_base_ff <= bank_pkg::ADDR_NONE;
			com4_base_ff <= bank_pkg::ADDR_NONE;
		end else begin
			hdd_if_enable_ff <= drive_osc_config_ff[bank_pkg::CR0_HDD_EN];
			drive_interface_type_ff <= drive_osc_config_ff[bank_pkg::CR0_IF_TYPE];
			floppy_power_on_ff <= drive_osc_config_ff[bank_pkg::CR0_FLP_PWR];
			floppy_unit_enable_ff <= drive_osc_config_ff[bank_pkg::CR0_FLP_EN];
			osc_enable_ff <= nxt_osc_enable;
			baud_clock_enable_ff <= nxt_osc_enable;
			config_valid_ff <= drive_osc_config_ff[bank_pkg::CR0_VALID];
			par_enable_ff <= par_sel != 2'h0;
			par_base_ff <= nxt_par_base;
			par_power_on_ff <= port_address_config_ff[bank_pkg::CR1_PAR_PWR];
			par_printer_mode_ff <= port_address_config_ff[bank_pkg::CR1_PAR_MODE];
			com3_base_ff <= nxt_com3_base;
			com4_base_ff <= nxt_com4_base;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_data_read;
		io_rd_stb && data_hit && access_ok;
	endsequence

	a_no_cfg_write: assert property (!mode_now |=> $stable(drive_osc_config_ff) && $stable(port_address_config_ff))
		else $error("register changed outside config mode");
	a_lock_sticky: assert property (!lock_open |=> !port_address_config_ff[bank_pkg::CR1_LOCK])
		else $error("lock bit returned without reset");
	a_locked_blocks: assert property (!lock_open && io_rd_stb |=> !data_oe_ff)
		else $error("read answered while locked");
	a_read_value: assert property (s_data_read |=> data_oe_ff && data_out_ff == $past(rd_mux) ##1 !data_oe_ff)
		else $error("read data wrong or held too long");
	a_index_first: assert property (io_rd_stb && data_hit && !index_loaded_ff |=> !data_oe_ff)
		else $error("data port answered before index load");
	a_reserved_zero: assert property (!drive_osc_config_ff[bank_pkg::CR0_RSVD])
		else $error("reserved bit set");
	a_osc_off: assert property (osc_mode == bank_pkg::OSC_OFF |=> !osc_enable_ff && !baud_clock_enable_ff)
		else $error("oscillator on while mode is off");
	a_osc_pg: assert property (osc_mode != bank_pkg::OSC_ALWAYS && !power_good_input |=> !osc_enable_ff)
		else $error("oscillator on without power good");
	a_par_disabled: assert property (par_sel == 2'h0 ##1 $stable(par_sel) |-> !par_enable_ff)
		else $error("parallel port enabled at code zero");
	a_sysreset_keep: assert property (sys_reset && !wr_data |=> $stable(port_address_config_ff))
		else $error("ordinary reset changed a register");

	// Outputs trail their fields by one cycle; starting on !rst keeps the
	// release edge, where outputs still hold reset values, out of the check
	a_hdd_follow: assert property (!rst |=>
		hdd_if_enable_ff == $past(drive_osc_config_ff[bank_pkg::CR0_HDD_EN]))
		else $error("drive interface enable not following its bit");
	a_type_follow: assert property (!rst |=>
		drive_interface_type_ff == $past(drive_osc_config_ff[bank_pkg::CR0_IF_TYPE]))
		else $error("interface type not following its bit");
	a_flp_pwr_follow: assert property (!rst |=>
		floppy_power_on_ff == $past(drive_osc_config_ff[bank_pkg::CR0_FLP_PWR]))
		else $error("floppy power not following its bit");
	a_flp_en_follow: assert property (!rst |=>
		floppy_unit_enable_ff == $past(drive_osc_config_ff[bank_pkg::CR0_FLP_EN]))
		else $error("floppy enable not following its bit");
	a_valid_follow: assert property (!rst |=>
		config_valid_ff == $past(drive_osc_config_ff[bank_pkg::CR0_VALID]))
		else $error("valid flag not following its bit");
	a_par_pwr_follow: assert property (!rst |=>
		par_power_on_ff == $past(port_address_config_ff[bank_pkg::CR1_PAR_PWR]))
		else $error("parallel power not following its bit");
	a_par_mode_follow: assert property (!rst |=>
		par_printer_mode_ff == $past(port_address_config_ff[bank_pkg::CR1_PAR_MODE]))
		else $error("printer mode not following its bit");

	// Clock gating codes that must leave both clocks running
	a_osc_always: assert property (!rst && osc_mode == bank_pkg::OSC_ALWAYS |=>
		osc_enable_ff && baud_clock_enable_ff)
		else $error("oscillator off in always-on mode");
	a_osc_pg_on: assert property (!rst && osc_mode != bank_pkg::OSC_OFF && power_good_input |=>
		osc_enable_ff && baud_clock_enable_ff)
		else $error("oscillator off while power good");

	// Address decode at the default codes, and parallel enable against base
	a_par_default: assert property (!rst && par_sel == 2'h3 |=>
		par_base_ff == bank_pkg::PAR_ADDR_3)
		else $error("parallel base wrong at code three");
	a_par_en_base: assert property (par_enable_ff == (par_base_ff != bank_pkg::ADDR_NONE))
		else $error("parallel enable and base disagree");
	a_com_default: assert property (!rst && com_sel == 2'h0 |=>
		com3_base_ff == bank_pkg::COM3_ADDR_0 && com4_base_ff == bank_pkg::COM4_ADDR_0)
		else $error("extra serial bases wrong at code zero");

	// Data port writes land as written outside the reserved and lock bits, and not at all while locked
	a_valid_write: assert property (wr_data && config_index_select_ff == bank_pkg::IDX_CR0 |=>
		drive_osc_config_ff[bank_pkg::CR0_VALID] == $past(data_in[bank_pkg::CR0_VALID]))
		else $error("valid flag not taken from write");
	a_cr1_write: assert property (wr_data && config_index_select_ff == bank_pkg::IDX_CR1 |=>
		port_address_config_ff[bank_pkg::CR1_LOCK-1:0] == $past(data_in[bank_pkg::CR1_LOCK-1:0]))
		else $error("register 1 write lost");
	a_lock_freeze: assert property (!lock_open |=>
		$stable(drive_osc_config_ff) && $stable(port_address_config_ff))
		else $error("register written while locked");

	// Index and answer discipline
	a_index_hold: assert property (!wr_sel |=> $stable(config_index_select_ff))
		else $error("index changed without a select write");
	a_loaded_clears: assert property (!mode_now |=> !index_loaded_ff)
		else $error("index kept outside config mode");
	a_no_answer_out: assert property (!mode_now && io_rd_stb |=> !data_oe_ff)
		else $error("read answered outside config mode");
	a_quiet_data: assert property (!data_oe_ff |-> data_out_ff == 8'h00)
		else $error("read data not idle between answers");

	// Interrupt pin forms seen from the polarity bit
	a_irq_oe_high: assert property (!rst && port_address_config_ff[bank_pkg::CR1_IRQ_POL] && !par_ext_active |=>
		irq_oe_ff == '1)
		else $error("interrupt pin released in active-high mode");
	a_irq_low_form: assert property (!port_address_config_ff[bank_pkg::CR1_IRQ_POL] |=>
		irq_out_ff == '0)
		else $error("interrupt pin driven high in active-low mode");
endmodule

//--- bank_pkg.sv
package bank_pkg;
	// Host port decode
	localparam logic [9:0] SELECT_PORT = 10'h3F0;
	localparam logic [9:0] DATA_PORT = 10'h3F1;
	localparam logic [7:0] UNLOCK_KEY = 8'h55;
	localparam logic [7:0] EXIT_KEY = 8'hAA;
	// Register indexes
	localparam logic [7:0] IDX_CR0 = 8'h00;
	localparam logic [7:0] IDX_CR1 = 8'h01;
	localparam logic [7:0] IDX_LIMIT = 8'h10;
	localparam int MEM_FIRST = 2;
	localparam int MEM_LAST = 15;
	// Power-up values
	localparam logic [7:0] CR0_DEF_A = 8'h3B;
	localparam logic [7:0] CR0_DEF_B = 8'h2B;
	localparam logic [7:0] CR1_DEF = 8'h9F;
	localparam logic [7:0] MEM_DEF = 8'h00;
	// Register 0 fields
	localparam int CR0_HDD_EN = 0;
	localparam int CR0_IF_TYPE = 1;
	localparam int CR0_RSVD = 2;
	localparam int CR0_FLP_PWR = 3;
	localparam int CR0_FLP_EN = 4;
	localparam int CR0_OSC_HI = 6;
	localparam int CR0_OSC_LO = 5;
	localparam int CR0_VALID = 7;
	localparam logic [1:0] OSC_ALWAYS = 2'h0;
	localparam logic [1:0] OSC_OFF = 2'h3;
	// Register 1 fields
	localparam int CR1_PAR_HI = 1;
	localparam int CR1_PAR_LO = 0;
	localparam int CR1_PAR_PWR = 2;
	localparam int CR1_PAR_MODE = 3;
	localparam int CR1_IRQ_POL = 4;
	localparam int CR1_COM_HI = 6;
	localparam int CR1_COM_LO = 5;
	localparam int CR1_LOCK = 7;
	// Address choices
	localparam logic [9:0] ADDR_NONE = 10'h000;
	localparam logic [9:0] PAR_ADDR_1 = 10'h3BC;
	localparam logic [9:0] PAR_ADDR_2 = 10'h378;
	localparam logic [9:0] PAR_ADDR_3 = 10'h278;
	localparam logic [9:0] COM3_ADDR_0 = 10'h338;
	localparam logic [9:0] COM3_ADDR_1 = 10'h3E8;
	localparam logic [9:0] COM3_ADDR_2 = 10'h2E8;
	localparam logic [9:0] COM3_ADDR_3 = 10'h220;
	localparam logic [9:0] COM4_ADDR_0 = 10'h238;
	localparam logic [9:0] COM4_ADDR_1 = 10'h2E8;
	localparam logic [9:0] COM4_ADDR_2 = 10'h2E0;
	localparam logic [9:0] COM4_ADDR_3 = 10'h228;
	// Interrupt lines: serial 1, serial 2, floppy, parallel
	localparam int IRQ_LINES = 4;
	localparam int IRQ_PAR = 3;
	typedef enum logic [1:0] {UNL_IDLE, UNL_ONE_KEY, UNL_CONFIG} unlock_state_type;
endpackage

//--- unlock_seq.sv
`timescale 1ns/100ps
module unlock_seq (
	// Clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic sys_reset,
	// Host write cycle
	input wire logic wr_stb,
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	// Mode
	output logic config_mode_ff
);
	bank_pkg::unlock_state_type state_ff;
	bank_pkg::unlock_state_type nxt_state;
	logic wr_key;
	logic wr_exit;
	logic prev_key_ff;

	// Only writes advance the sequence, and only writes or sys_reset break it; reads pass unseen
	assign wr_key = wr_stb && addr == bank_pkg::SELECT_PORT && wdata == bank_pkg::UNLOCK_KEY;
	assign wr_exit = wr_stb && addr == bank_pkg::SELECT_PORT && wdata == bank_pkg::EXIT_KEY;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			bank_pkg::UNL_IDLE: begin
				if (wr_key) begin
					nxt_state = bank_pkg::UNL_ONE_KEY;
				end
			end
			bank_pkg::UNL_ONE_KEY: begin
				if (wr_key) begin
					nxt_state = bank_pkg::UNL_CONFIG;
				end else if (wr_stb) begin
					nxt_state = bank_pkg::UNL_IDLE;
				end
			end
			bank_pkg::UNL_CONFIG: begin
				if (wr_exit) begin
					nxt_state = bank_pkg::UNL_IDLE;
				end
			end
			default: nxt_state = bank_pkg::UNL_IDLE;
		endcase
		if (sys_reset) begin
			nxt_state = bank_pkg::UNL_IDLE;
		end
	end

	// Mode flag kept in step with the state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= bank_pkg::UNL_IDLE;
			config_mode_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			config_mode_ff <= nxt_state == bank_pkg::UNL_CONFIG;
		end
	end

	// Checking helper: last write was a key
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_key_ff <= 1'b0;
		end else if (wr_stb) begin
			prev_key_ff <= wr_key;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Host strobes come every other cycle, so the pair has one idle cycle and no write between
	sequence s_two_keys;
		(wr_key && !sys_reset) ##1 (!wr_stb && !sys_reset) ##1 (wr_key && !sys_reset);
	endsequence

	a_enter_after_keys: assert property (!config_mode_ff ##0 s_two_keys |=> config_mode_ff)
		else $error("two keys did not enter config mode");
	a_enter_needs_pair: assert property ($rose(config_mode_ff) |-> $past(wr_key && prev_key_ff))
		else $error("config mode entered without two keys");
	a_exit_on_key: assert property (config_mode_ff && wr_exit |=> !config_mode_ff)
		else $error("exit key did not leave config mode");
endmodule

//--- irq_drive.sv
`timescale 1ns/100ps
module irq_drive (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Polarity control
	input wire logic active_high,
	input wire logic par_ext_mode,
	// Raw requests, active high
	input wire logic [bank_pkg::IRQ_LINES-1:0] irq_raw,
	// Pin drive
	output logic [bank_pkg::IRQ_LINES-1:0] irq_out_ff,
	output logic [bank_pkg::IRQ_LINES-1:0] irq_oe_ff
);
	genvar i;
	generate
		for (i = 0; i < bank_pkg::IRQ_LINES; i++) begin : g_line
			logic high_mode;
			// Extended parallel modes share the line, so it must be open-drain style
			if (i == bank_pkg::IRQ_PAR) begin : g_par
				assign high_mode = active_high && !par_ext_mode;
			end else begin : g_other
				assign high_mode = active_high;
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					irq_out_ff[i] <= 1'b0;
					irq_oe_ff[i] <= 1'b1;
				end else begin
					irq_out_ff[i] <= high_mode && irq_raw[i];
					irq_oe_ff[i] <= high_mode || irq_raw[i];
				end
			end
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_par_ext_low: assert property (par_ext_mode && irq_raw[bank_pkg::IRQ_PAR] |=>
		irq_oe_ff[bank_pkg::IRQ_PAR] && !irq_out_ff[bank_pkg::IRQ_PAR])
		else $error("parallel interrupt not active low in extended mode");
endmodule

//--- isa_host.sv
`timescale 1ns/100ps
module isa_host (
	// Clock
	input wire logic clk,
	// Host cycle
	output logic [9:0] io_addr,
	output logic io_wr_stb,
	output logic io_rd_stb,
	output logic [7:0] data_in,
	// Answer
	input wire logic [7:0] data_out_ff,
	input wire logic data_oe_ff
);
	initial begin
		io_addr = 10'h000;
		io_wr_stb = 1'b0;
		io_rd_stb = 1'b0;
		data_in = 8'h00;
	end

	// One strobe cycle; lines inverted once released so stale values never pass
	task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic w);
		@(posedge clk);
		io_addr <= a;
		data_in <= d;
		io_wr_stb <= w;
		io_rd_stb <= !w;
		@(posedge clk);
		io_wr_stb <= 1'b0;
		io_rd_stb <= 1'b0;
		io_addr <= ~a;
		data_in <= ~d;
	endtask

	// Write cycle, no answer expected
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		cyc(a, d, 1'b1);
	endtask

	// Read cycle; answer stands only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, output logic oe, output logic [7:0] d);
		cyc(a, 8'h00, 1'b0);
		#1;
		oe = data_oe_ff;
		d = data_out_ff;
	endtask
endmodule

//--- config_index_data_bank_tb.sv
`timescale 1ns/100ps
module config_index_data_bank_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sys_reset = 1'b0;
	logic power_good_input = 1'b1;
	logic par_ext_active = 1'b0;
	logic [3:0] irq_raw = 4'h0;
	logic [9:0] io_addr;
	logic io_wr_stb;
	logic io_rd_stb;
	logic [7:0] data_in;
	logic [7:0] data_out_ff;
	logic data_oe_ff, config_mode_ff, hdd_if_enable_ff, drive_interface_type_ff;
	logic floppy_power_on_ff, floppy_unit_enable_ff, osc_enable_ff, baud_clock_enable_ff;
	logic config_valid_ff, par_enable_ff, par_power_on_ff, par_printer_mode_ff;
	logic [9:0] par_base_ff, com3_base_ff, com4_base_ff;
	logic [3:0] irq_out_ff, irq_oe_ff;
	logic flp_en_b;
	logic [9:0] pb [4] = '{10'h000, 10'h3BC, 10'h378, 10'h278};
	logic [9:0] c3 [4] = '{10'h338, 10'h3E8, 10'h2E8, 10'h220};
	logic [9:0] c4 [4] = '{10'h238, 10'h2E8, 10'h2E0, 10'h228};
	int regs [16];
	int idx, n_errors, cmp_count, i;
	bit cfg, key1, idx_ok;
	integer seed = 32'h0A5BA5F2;
	logic [7:0] v;

	always #5 clk = ~clk;

	config_index_data_bank #(.VARIANT_B(1'b0)) dut (.clk(clk), .rst(rst), .sys_reset(sys_reset),
		.io_addr(io_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .data_in(data_in),
		.data_out_ff(data_out_ff), .data_oe_ff(data_oe_ff), .power_good_input(power_good_input),
		.par_ext_active(par_ext_active), .irq_raw(irq_raw), .config_mode_ff(config_mode_ff),
		.hdd_if_enable_ff(hdd_if_enable_ff), .drive_interface_type_ff(drive_interface_type_ff),
		.floppy_power_on_ff(floppy_power_on_ff), .floppy_unit_enable_ff(floppy_unit_enable_ff),
		.osc_enable_ff(osc_enable_ff), .baud_clock_enable_ff(baud_clock_enable_ff),
		.config_valid_ff(config_valid_ff), .par_enable_ff(par_enable_ff), .par_base_ff(par_base_ff),
		.par_power_on_ff(par_power_on_ff), .par_printer_mode_ff(par_printer_mode_ff),
		.com3_base_ff(com3_base_ff), .com4_base_ff(com4_base_ff), .irq_out_ff(irq_out_ff),
		.irq_oe_ff(irq_oe_ff));

	// Other variant on the same bus, to see its own register 0 default
	config_index_data_bank #(.VARIANT_B(1'b1)) dut_b (.clk(clk), .rst(rst), .sys_reset(sys_reset),
		.io_addr(io_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .data_in(data_in),
		.data_out_ff(), .data_oe_ff(), .power_good_input(power_good_input),
		.par_ext_active(par_ext_active), .irq_raw(irq_raw), .config_mode_ff(),
		.hdd_if_enable_ff(), .drive_interface_type_ff(), .floppy_power_on_ff(),
		.floppy_unit_enable_ff(flp_en_b), .osc_enable_ff(), .baud_clock_enable_ff(),
		.config_valid_ff(), .par_enable_ff(), .par_base_ff(), .par_power_on_ff(),
		.par_printer_mode_ff(), .com3_base_ff(), .com4_base_ff(), .irq_out_ff(), .irq_oe_ff());

	isa_host host (.clk(clk), .io_addr(io_addr), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb),
		.data_in(data_in), .data_out_ff(data_out_ff), .data_oe_ff(data_oe_ff));

	// Verdict and counts, also reached from the watchdog
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Model state after power-up or hard reset
	task automatic mreset();
		foreach (regs[k])
			regs[k] = 0;
		regs[0] = 'h3B;
		regs[1] = 'h9F;
		cfg = 0;
		key1 = 0;
		idx_ok = 0;
	endtask

	function automatic bit open();
		return cfg && idx_ok && idx < 16 && regs[1][7];
	endfunction

	// Host write plus the model's view of it
	task automatic mwr(input logic [9:0] a, input logic [7:0] d);
		host.wr(a, d);
		if (cfg && a == bank_pkg::SELECT_PORT && d == bank_pkg::EXIT_KEY) begin
			cfg = 0;
		end else if (cfg && a == bank_pkg::SELECT_PORT) begin
			idx = d;
			idx_ok = 1;
		end else if (cfg && a == bank_pkg::DATA_PORT) begin
			if (open())
				regs[idx] = d;
		end else if (!cfg && a == bank_pkg::SELECT_PORT && d == bank_pkg::UNLOCK_KEY) begin
			cfg = key1;
			idx_ok = 0;
			key1 = !key1;
		end else begin
			key1 = 0;
		end
	endtask

	// Two back-to-back keys, nothing in between
	task automatic enter();
		mwr(bank_pkg::SELECT_PORT, bank_pkg::UNLOCK_KEY);
		mwr(bank_pkg::SELECT_PORT, bank_pkg::UNLOCK_KEY);
	endtask

	task automatic mrd();
		logic oe;
		logic [7:0] d;
		bit en;
		en = open();
		host.rd(bank_pkg::DATA_PORT, oe, d);
		check(oe, en);
		check(d, en ? regs[idx] : 0);
	endtask

	// Control outputs against the model registers
	task automatic chk_out();
		int r0, r1, on;
		r0 = regs[0];
		r1 = regs[1];
		repeat (2) @(posedge clk);
		#1;
		on = (r0 >> 5 & 3) == 0 || ((r0 >> 5 & 3) != 3 && power_good_input);
		check(hdd_if_enable_ff, r0 & 1);
		check(drive_interface_type_ff, r0 >> 1 & 1);
		check(floppy_power_on_ff, r0 >> 3 & 1);
		check(floppy_unit_enable_ff, r0 >> 4 & 1);
		check(osc_enable_ff, on);
		check(baud_clock_enable_ff, on);
		check(config_valid_ff, r0 >> 7 & 1);
		check(par_enable_ff, (r1 & 3) != 0);
		check(par_base_ff, pb[r1 & 3]);
		check(par_power_on_ff, r1 >> 2 & 1);
		check(par_printer_mode_ff, r1 >> 3 & 1);
		check(com3_base_ff, c3[r1 >> 5 & 3]);
		check(com4_base_ff, c4[r1 >> 5 & 3]);
		check(config_mode_ff, cfg);
	endtask

	// Interrupt pin form for the current polarity and parallel mode
	task automatic chk_irq(input logic [3:0] raw, input logic ext);
		logic [3:0] eo, ee;
		@(posedge clk);
		irq_raw <= raw;
		par_ext_active <= ext;
		repeat (2) @(posedge clk);
		#1;
		eo = regs[1][4] ? raw : 4'h0;
		ee = regs[1][4] ? 4'hF : raw;
		if (ext) begin
			eo[3] = 1'b0;
			ee[3] = raw[3];
		end
		check(irq_out_ff, eo);
		check(irq_oe_ff, ee);
	endtask

	// Watchdog so a hang still ends in a verdict
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	initial begin
		mreset();
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk_out();
		check(flp_en_b, 'h2B >> 4 & 1);
		// Outside config mode the data port is dead
		mwr(bank_pkg::DATA_PORT, 8'h00);
		mrd();
		// A foreign write between keys spoils entry
		mwr(bank_pkg::SELECT_PORT, bank_pkg::UNLOCK_KEY);
		mwr(10'h2F8, 8'h55);
		mwr(bank_pkg::SELECT_PORT, bank_pkg::UNLOCK_KEY);
		chk_out();
		enter();
		chk_out();
		mrd();
		for (i = 0; i < 17; i++) begin
			mwr(bank_pkg::SELECT_PORT, i[7:0]);
			mrd();
		end
		// Plain storage above register 1
		for (i = 2; i < 16; i++) begin
			mwr(bank_pkg::SELECT_PORT, i[7:0]);
			mwr(bank_pkg::DATA_PORT, 8'($random(seed)));
			mrd();
		end
		// Every oscillator code, power good both ways; reserved bit written as zero
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			power_good_input <= i[2];
			v = (8'($random(seed)) & 8'h9B) | 8'(i[1:0] << 5);
			mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR0);
			mwr(bank_pkg::DATA_PORT, v);
			mrd();
			chk_out();
		end
		// Every port code and both polarities, lock kept open
		for (i = 0; i < 4; i++) begin
			v = 8'h80 | 8'(i << 5) | 8'(3 - i) | 8'(i[0] << 4) | (8'($random(seed)) & 8'h0C);
			mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR1);
			mwr(bank_pkg::DATA_PORT, v);
			mrd();
			chk_out();
			chk_irq({i[1] ^ i[0], 3'($random(seed))}, i[1]);
		end
		// Ordinary reset drops the mode only
		@(posedge clk);
		sys_reset <= 1'b1;
		@(posedge clk);
		sys_reset <= 1'b0;
		cfg = 0;
		key1 = 0;
		chk_out();
		enter();
		mrd();
		mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR0);
		mrd();
		// Exit, then writes are ignored
		mwr(bank_pkg::SELECT_PORT, bank_pkg::EXIT_KEY);
		mwr(bank_pkg::DATA_PORT, 8'h00);
		chk_out();
		enter();
		mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR0);
		mrd();
		// Clearing the lock blocks every data port access, even setting it again
		mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR1);
		mwr(bank_pkg::DATA_PORT, 8'(regs[1] & 'h7F));
		mrd();
		mwr(bank_pkg::DATA_PORT, 8'hFF);
		mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR0);
		mwr(bank_pkg::DATA_PORT, 8'h00);
		mrd();
		chk_out();
		// Hard reset brings back defaults and the lock
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		mreset();
		chk_out();
		enter();
		mwr(bank_pkg::SELECT_PORT, bank_pkg::IDX_CR1);
		mrd();
		end_of_test();
	end
endmodule
